/* rtl/agc_consts.vh */
// constants of the adc global control register bank
// What this block does
// - register space is paged; an 8-bit page selector sits at offset zero
// - writing one to the soft reset bit restores every register to its default
// - the soft reset bit clears itself once the reset has been carried out
// - quick-charge field bits 4-3 picks 3.5, 10, 50 or 100 ms charge time
// - broadcast bit zero uses address pins; one answers fixed address 1001 100
// - active-low sleep bit 0 holds sleep while zero; writing one leaves sleep
// - shutdown field bits 3-2: off at once, off after timeout, clean, reserved
// - keep-alive field bits 1-0 gives 30, 25, 10 or 5 ms, code 1 at reset
// - first serial audio byte resets to 0x30 with format, length, polarities, edge, fill
// - audio format codes: 0 tdm, 1 i2s, 2 left-justified, 3 reserved
// - word length codes 0 to 3 give 16, 20, 24 or 32 bits
// - fill clear drives zero on unused cycles; fill set leaves them high impedance
`ifndef AGC_CONSTS_VH
`define AGC_CONSTS_VH

`define AGC_OFS_PAGE_SELECT     8'h00
`define AGC_OFS_SOFT_RESET      8'h01
`define AGC_OFS_SLEEP_CONFIG    8'h02
`define AGC_OFS_SHUTDOWN_CONFIG 8'h05
`define AGC_OFS_AUDIO_CONFIG    8'h07

`define AGC_RST_PAGE_SELECT     8'h00
`define AGC_RST_SOFT_RESET      8'h00
`define AGC_RST_SLEEP_CONFIG    8'h00
`define AGC_RST_SHUTDOWN_CONFIG 8'h05
`define AGC_RST_AUDIO_CONFIG    8'h30

// sleep_config fields
`define AGC_SLP_EXIT_BIT        0
`define AGC_SLP_BCAST_BIT       2
`define AGC_SLP_QCHG_LSB        3
`define AGC_SLP_RSVD_RW_MSB     7
`define AGC_SLP_RSVD_RW_LSB     5

// shutdown_config fields
`define AGC_SHD_KA_LSB          0
`define AGC_SHD_POLICY_LSB      2

// audio config fields
`define AGC_AUD_FILL_BIT        0
`define AGC_AUD_EDGE_BIT        1
`define AGC_AUD_BIT_CLOCK_POLARITY_BIT    2
`define AGC_AUD_FRAME_SYNC_POLARITY_BIT   3
`define AGC_AUD_WLEN_LSB        4
`define AGC_AUD_FMT_LSB         6

// shutdown policy codes
`define AGC_POL_IMMEDIATE       2'h0
`define AGC_POL_TIMEOUT         2'h1
`define AGC_POL_CLEAN           2'h2

// i2c addresses
`define AGC_I2C_BCAST_ADDR      7'h4c

// timing, in microseconds, and the clock rate
`define AGC_CLK_MHZ             250
`define AGC_QCHG0_US            3500
`define AGC_QCHG1_US            10000
`define AGC_QCHG2_US            50000
`define AGC_QCHG3_US            100000
`define AGC_KA0_US              30000
`define AGC_KA1_US              25000
`define AGC_KA2_US              10000
`define AGC_KA3_US              5000

`endif

/* rtl/agc_timer.v */
// one-shot down counter used for the charge and keep-alive windows
`timescale 1ns/1ns
`default_nettype none
module agc_timer #(
    parameter W = 32
) (
    input  wire         core_clk,
    input  wire         reset,
    input  wire         start,
    input  wire         abort,
    input  wire [W-1:0] load_value,
    output reg          busy,
    output reg          done
);
    reg [W-1:0] count;

    // busy stands for load_value cycles, then done pulses once
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            count <= {W{1'b0}};
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (abort) begin
                busy <= 1'b0;
            end else if (start) begin
                count <= load_value;
                busy  <= 1'b1;
            end else if (busy) begin
                if (count <= {{(W-1){1'b0}}, 1'b1}) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count <= count - {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule
`default_nettype wire

/* rtl/agc_regs.v */
// global control register bank: paging, soft reset, sleep, shutdown, audio byte
`timescale 1ns/1ns
`default_nettype none
`include "agc_consts.vh"
module agc_regs #(
    parameter [31:0] QCHG0_CYCLES  = `AGC_QCHG0_US * `AGC_CLK_MHZ,
    parameter [31:0] QCHG1_CYCLES  = `AGC_QCHG1_US * `AGC_CLK_MHZ,
    parameter [31:0] QCHG2_CYCLES  = `AGC_QCHG2_US * `AGC_CLK_MHZ,
    parameter [31:0] QCHG3_CYCLES  = `AGC_QCHG3_US * `AGC_CLK_MHZ,
    parameter [31:0] KA0_CYCLES    = `AGC_KA0_US * `AGC_CLK_MHZ,
    parameter [31:0] KA1_CYCLES    = `AGC_KA1_US * `AGC_CLK_MHZ,
    parameter [31:0] KA2_CYCLES    = `AGC_KA2_US * `AGC_CLK_MHZ,
    parameter [31:0] KA3_CYCLES    = `AGC_KA3_US * `AGC_CLK_MHZ,
    // base of the pin-strapped i2c address; arbitrary value
    parameter [6:0]  I2C_PIN_BASE  = 7'h48
) (
    input  wire       core_clk,
    input  wire       reset,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata,
    output reg        reg_rvalid,
    input  wire [1:0] address_pins,
    input  wire       shutdown_pin_n,
    input  wire       clean_shutdown_done,
    output reg  [7:0] page_select,
    output reg        soft_reset_pulse,
    output reg        sleep_mode,
    output reg        reference_quick_charge,
    output reg  [6:0] i2c_target_address,
    output reg        digital_regulator_enable,
    output reg  [1:0] audio_format_select,
    output reg        audio_format_reserved,
    output reg  [1:0] audio_word_length,
    output reg  [5:0] audio_slot_bits,
    output reg        frame_sync_polarity,
    output reg        bit_clock_polarity,
    output reg        audio_tx_edge,
    output reg        unused_cycle_drive_zero
);
    localparam [1:0] ST_RUN   = 2'h0;
    localparam [1:0] ST_HOLD  = 2'h1;
    localparam [1:0] ST_CLEAN = 2'h2;
    localparam [1:0] ST_OFF   = 2'h3;
    localparam [7:0] SHD_RST  = `AGC_RST_SHUTDOWN_CONFIG;

    reg        soft_reset_trigger;
    reg [2:0]  sleep_reserved;
    reg [1:0]  reference_quick_charge_time;
    reg        broadcast_address_enable;
    reg        sleep_exit_n;
    reg [1:0]  shutdown_policy;
    reg [1:0]  regulator_keepalive_time;
    reg [7:0]  audio_config;
    reg        sleep_exit_prev;
    reg [1:0]  shd_state;
    reg [1:0]  next_shd_state;
    reg [31:0] qchg_load;
    reg [31:0] ka_load;
    reg [7:0]  next_rdata;
    reg [5:0]  next_slot_bits;

    wire       page_zero = (page_select == 8'h00);
    wire       wr_soft   = reg_wr && page_zero && (reg_addr == `AGC_OFS_SOFT_RESET);
    wire       wr_sleep  = reg_wr && page_zero && (reg_addr == `AGC_OFS_SLEEP_CONFIG);
    wire       wr_shd    = reg_wr && page_zero && (reg_addr == `AGC_OFS_SHUTDOWN_CONFIG);
    wire       wr_audio  = reg_wr && page_zero && (reg_addr == `AGC_OFS_AUDIO_CONFIG);
    wire       wr_page   = reg_wr && (reg_addr == `AGC_OFS_PAGE_SELECT);
    wire       qc_busy;
    wire       ka_done;
    wire       qc_start  = sleep_exit_n && !sleep_exit_prev;
    wire       ka_start  = (shd_state == ST_RUN) && !shutdown_pin_n &&
                           (shutdown_policy == `AGC_POL_TIMEOUT);

    // register writes; a pending soft reset reloads every default
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            page_select                 <= `AGC_RST_PAGE_SELECT;
            soft_reset_trigger          <= 1'b0;
            sleep_reserved              <= 3'h0;
            reference_quick_charge_time <= 2'h0;
            broadcast_address_enable    <= 1'b0;
            sleep_exit_n                <= 1'b0;
            shutdown_policy             <= SHD_RST[3:2];
            regulator_keepalive_time    <= SHD_RST[1:0];
            audio_config                <= `AGC_RST_AUDIO_CONFIG;
        end else if (soft_reset_trigger) begin
            page_select                 <= `AGC_RST_PAGE_SELECT;
            soft_reset_trigger          <= 1'b0;
            sleep_reserved              <= 3'h0;
            reference_quick_charge_time <= 2'h0;
            broadcast_address_enable    <= 1'b0;
            sleep_exit_n                <= 1'b0;
            shutdown_policy             <= SHD_RST[3:2];
            regulator_keepalive_time    <= SHD_RST[1:0];
            audio_config                <= `AGC_RST_AUDIO_CONFIG;
        end else begin
            if (wr_page) begin
                page_select <= reg_wdata;
            end
            if (wr_soft && reg_wdata[0]) begin
                soft_reset_trigger <= 1'b1;
            end
            if (wr_sleep) begin
                // bit 1 is read-only reserved and is not stored
                sleep_reserved              <= reg_wdata[7:5];
                reference_quick_charge_time <= reg_wdata[4:3];
                broadcast_address_enable    <= reg_wdata[`AGC_SLP_BCAST_BIT];
                sleep_exit_n                <= reg_wdata[`AGC_SLP_EXIT_BIT];
            end
            if (wr_shd) begin
                shutdown_policy          <= reg_wdata[3:2];
                regulator_keepalive_time <= reg_wdata[1:0];
            end
            if (wr_audio) begin
                audio_config <= reg_wdata;
            end
        end
    end

    // read mux; read-only reserved bits return zero
    always @* begin
        next_rdata = 8'h00;
        if (reg_addr == `AGC_OFS_PAGE_SELECT) begin
            next_rdata = page_select;
        end else if (page_zero) begin
            case (reg_addr)
                `AGC_OFS_SOFT_RESET: begin
                    next_rdata = {7'h00, soft_reset_trigger};
                end
                `AGC_OFS_SLEEP_CONFIG: begin
                    next_rdata = {sleep_reserved, reference_quick_charge_time,
                                  broadcast_address_enable, 1'b0, sleep_exit_n};
                end
                `AGC_OFS_SHUTDOWN_CONFIG: begin
                    next_rdata = {4'h0, shutdown_policy, regulator_keepalive_time};
                end
                `AGC_OFS_AUDIO_CONFIG: begin
                    next_rdata = audio_config;
                end
                default: begin
                    next_rdata = 8'h00;
                end
            endcase
        end
    end

    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // window lengths selected by the charge and keep-alive codes
    always @* begin
        case (reference_quick_charge_time)
            2'h0:    qchg_load = QCHG0_CYCLES;
            2'h1:    qchg_load = QCHG1_CYCLES;
            2'h2:    qchg_load = QCHG2_CYCLES;
            default: qchg_load = QCHG3_CYCLES;
        endcase
        case (regulator_keepalive_time)
            2'h0:    ka_load = KA0_CYCLES;
            2'h1:    ka_load = KA1_CYCLES;
            2'h2:    ka_load = KA2_CYCLES;
            default: ka_load = KA3_CYCLES;
        endcase
    end

    agc_timer #(.W(32)) u_qchg_timer (
        .core_clk   (core_clk),
        .reset      (reset),
        .start      (qc_start),
        .abort      (!sleep_exit_n),
        .load_value (qchg_load),
        .busy       (qc_busy),
        .done       ()
    );

    agc_timer #(.W(32)) u_ka_timer (
        .core_clk   (core_clk),
        .reset      (reset),
        .start      (ka_start),
        .abort      (shutdown_pin_n),
        .load_value (ka_load),
        .busy       (),
        .done       (ka_done)
    );

    // regulator policy on shutdown pin assertion; reserved code acts as immediate
    always @* begin
        next_shd_state = shd_state;
        case (shd_state)
            ST_RUN: begin
                if (!shutdown_pin_n) begin
                    case (shutdown_policy)
                        `AGC_POL_TIMEOUT: next_shd_state = ST_HOLD;
                        `AGC_POL_CLEAN:   next_shd_state = ST_CLEAN;
                        default:          next_shd_state = ST_OFF;
                    endcase
                end
            end
            ST_HOLD: begin
                if (shutdown_pin_n) begin
                    next_shd_state = ST_RUN;
                end else if (ka_done || clean_shutdown_done) begin
                    next_shd_state = ST_OFF;
                end
            end
            ST_CLEAN: begin
                if (shutdown_pin_n) begin
                    next_shd_state = ST_RUN;
                end else if (clean_shutdown_done) begin
                    next_shd_state = ST_OFF;
                end
            end
            ST_OFF: begin
                if (shutdown_pin_n) begin
                    next_shd_state = ST_RUN;
                end
            end
            default: begin
                next_shd_state = ST_RUN;
            end
        endcase
    end

    always @* begin
        case (audio_config[5:4])
            2'h0:    next_slot_bits = 6'h10;
            2'h1:    next_slot_bits = 6'h14;
            2'h2:    next_slot_bits = 6'h18;
            default: next_slot_bits = 6'h20;
        endcase
    end

    // registered outputs
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            shd_state                <= ST_RUN;
            sleep_exit_prev          <= 1'b0;
            soft_reset_pulse         <= 1'b0;
            sleep_mode               <= 1'b1;
            reference_quick_charge   <= 1'b0;
            i2c_target_address       <= I2C_PIN_BASE;
            digital_regulator_enable <= 1'b1;
            audio_format_select      <= 2'h0;
            audio_format_reserved    <= 1'b0;
            audio_word_length        <= 2'h3;
            audio_slot_bits          <= 6'h20;
            frame_sync_polarity      <= 1'b0;
            bit_clock_polarity       <= 1'b0;
            audio_tx_edge            <= 1'b0;
            unused_cycle_drive_zero  <= 1'b1;
        end else begin
            shd_state                <= next_shd_state;
            sleep_exit_prev          <= sleep_exit_n;
            soft_reset_pulse         <= soft_reset_trigger;
            sleep_mode               <= !sleep_exit_n;
            reference_quick_charge   <= qc_busy || qc_start;
            if (broadcast_address_enable) begin
                i2c_target_address <= `AGC_I2C_BCAST_ADDR;
            end else begin
                i2c_target_address <= I2C_PIN_BASE | {5'h00, address_pins};
            end
            digital_regulator_enable <= (next_shd_state != ST_OFF);
            audio_format_select      <= audio_config[7:6];
            audio_format_reserved    <= (audio_config[7:6] == 2'h3);
            audio_word_length        <= audio_config[5:4];
            audio_slot_bits          <= next_slot_bits;
            frame_sync_polarity      <= audio_config[`AGC_AUD_FRAME_SYNC_POLARITY_BIT];
            bit_clock_polarity       <= audio_config[`AGC_AUD_BIT_CLOCK_POLARITY_BIT];
            audio_tx_edge            <= audio_config[`AGC_AUD_EDGE_BIT];
            unused_cycle_drive_zero  <= !audio_config[`AGC_AUD_FILL_BIT];
        end
    end
endmodule
`default_nettype wire

/* sim/agc_checker.sv */
// assertions on the ports of the global control register bank
`timescale 1ns/1ns
`default_nettype none
module agc_checker (
    input wire logic       core_clk,
    input wire logic       reset,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic       reg_rvalid,
    input wire logic       shutdown_pin_n,
    input wire logic       soft_reset_pulse,
    input wire logic [7:0] page_select,
    input wire logic       sleep_mode,
    input wire logic       reference_quick_charge,
    input wire logic       digital_regulator_enable,
    input wire logic [1:0] audio_format_select,
    input wire logic       audio_format_reserved,
    input wire logic [1:0] audio_word_length,
    input wire logic [5:0] audio_slot_bits,
    input wire logic       unused_cycle_drive_zero
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    AST_RD_ANSWER: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered");
    AST_RD_QUIET: assert property (!reg_rd |=> !reg_rvalid)
        else $error("read answer without request");
    AST_SRST_ONCE: assert property (soft_reset_pulse |=> !soft_reset_pulse)
        else $error("soft reset did not clear");
    AST_SRST_DEFAULT: assert property (soft_reset_pulse |=> page_select == 8'h00
        && sleep_mode && audio_word_length == 2'h3 && audio_format_select == 2'h0)
        else $error("defaults not restored");
    AST_SLOT_DECODE: assert property (audio_slot_bits == (audio_word_length == 2'h0 ? 6'd16 :
        audio_word_length == 2'h1 ? 6'd20 : audio_word_length == 2'h2 ? 6'd24 : 6'd32))
        else $error("slot length decode wrong");
    AST_FMT_RSVD: assert property (audio_format_reserved == (audio_format_select == 2'h3))
        else $error("reserved format flag wrong");
    AST_QCHG_AWAKE: assert property ($rose(reference_quick_charge) |-> ##[0:2] !sleep_mode)
        else $error("quick charge while asleep");
    AST_REG_ON: assert property (shutdown_pin_n [*2] |-> digital_regulator_enable)
        else $error("regulator off with pin high");
    AST_REG_OFF_CAUSE: assert property ($fell(digital_regulator_enable) |-> !$past(shutdown_pin_n))
        else $error("regulator off without pin");
    AST_CFG_STABLE: assert property (!reg_wr ##1 (!reg_wr && !soft_reset_pulse) |=>
        $stable(unused_cycle_drive_zero) && $stable(audio_format_select))
        else $error("config changed without write");
endmodule

bind agc_regs agc_checker i_agc_checker (.*);
`default_nettype wire

/* sim/agc_host.sv */
// control port host model that writes and reads the register bank
`timescale 1ns/1ns
`default_nettype none
module agc_host (
    input  wire logic       core_clk,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h5a;
        reg_wdata = 8'ha5;
    end

    // callers put reset values into reserved positions
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        d = 8'h00;
        ok = 1'b0;
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge core_clk);
            if (reg_rvalid === 1'b1) begin
                d = reg_rdata;
                ok = 1'b1;
            end
        end
    endtask
endmodule
`default_nettype wire

/* sim/agc_regs_bench.sv */
// self-checking bench for the global control register bank
`timescale 1ns/1ns
`default_nettype none
module agc_regs_bench;
    // charge codes 2-3 and keep-alive code 0 keep full-length windows that outlast the look
    localparam int QL[4] = '{20, 40, 199, 199};
    localparam int QH[4] = '{23, 43, 199, 199};
    localparam int KL[4] = '{300, 60, 40, 20};
    localparam int KH[4] = '{300, 66, 46, 26};
    localparam int SB[4] = '{16, 20, 24, 32};
    logic            core_clk = 1'b0;
    logic            reset = 1'b1;
    logic [1:0]      address_pins = 2'h0;
    logic            shutdown_pin_n = 1'b1;
    logic            clean_shutdown_done = 1'b0;
    wire logic       reg_wr, reg_rd, reg_rvalid, soft_reset_pulse, sleep_mode;
    wire logic       reference_quick_charge, digital_regulator_enable, audio_format_reserved;
    wire logic       frame_sync_polarity, bit_clock_polarity, audio_tx_edge;
    wire logic       unused_cycle_drive_zero;
    wire logic [7:0] reg_addr, reg_wdata, reg_rdata, page_select;
    wire logic [6:0] i2c_target_address;
    wire logic [1:0] audio_format_select, audio_word_length;
    wire logic [5:0] audio_slot_bits;
    int              bad_count = 0;
    int              checks = 0;

    always #2 core_clk = ~core_clk;

    agc_regs #(.QCHG0_CYCLES(32'd20), .QCHG1_CYCLES(32'd40), .KA1_CYCLES(32'd60),
        .KA2_CYCLES(32'd40), .KA3_CYCLES(32'd20)) i_agc_regs (.*);
    agc_host i_agc_host (.*);

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", n, exp, seen);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       ok;
        i_agc_host.rd(a, d, ok);
        if (ok !== 1'b1) begin
            bad_count++;
            stop_test();
        end
        check($sformatf("offset %0h", a), d, e);
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic t_defaults();
        rdc(8'h00, 8'h00);
        rdc(8'h01, 8'h00);
        rdc(8'h02, 8'h00);
        rdc(8'h05, 8'h05);
        rdc(8'h07, 8'h30);
        check("sleep", sleep_mode, 1);
        check("slot", audio_slot_bits, 32);
        check("addr", i2c_target_address, 7'h48);
        $display("defaults done");
    endtask

    task automatic t_paging_reserved();
        i_agc_host.wr(8'h00, 8'hff);
        wt(1);
        check("page", page_select, 8'hff);
        rdc(8'h00, 8'hff);
        i_agc_host.wr(8'h07, 8'h00);
        rdc(8'h07, 8'h00);
        i_agc_host.wr(8'h00, 8'h00);
        rdc(8'h07, 8'h30);
        rdc(8'h03, 8'h00);
        i_agc_host.wr(8'h01, 8'h00);
        rdc(8'h01, 8'h00);
        rdc(8'h07, 8'h30);
        i_agc_host.wr(8'h05, 8'h0f);
        rdc(8'h05, 8'h0f);
        i_agc_host.wr(8'h02, 8'h1c);
        rdc(8'h02, 8'h1c);
        i_agc_host.wr(8'h02, 8'h00);
        i_agc_host.wr(8'h05, 8'h05);
        $display("paging and reserved done");
    endtask

    task automatic t_audio();
        logic [7:0] v;
        for (int f = 0; f < 4; f++) begin
            for (int w = 0; w < 4; w++) begin
                v = {f[1:0], w[1:0], w[1:0], f[1:0]};
                i_agc_host.wr(8'h07, v);
                wt(2);
                check("fmt", audio_format_select, f[1:0]);
                check("fmt rsvd", audio_format_reserved, f == 3);
                check("wlen", audio_word_length, w[1:0]);
                check("slot", audio_slot_bits, SB[w]);
                check("pol", {frame_sync_polarity, bit_clock_polarity, audio_tx_edge}, v[3:1]);
                check("fill", unused_cycle_drive_zero, !v[0]);
                rdc(8'h07, v);
            end
        end
        $display("audio done");
    endtask

    task automatic t_sleep();
        int n;
        @(posedge core_clk);
        address_pins <= 2'h1;
        i_agc_host.wr(8'h02, 8'h04);
        wt(3);
        check("bcast", i2c_target_address, 7'h4c);
        for (int q = 0; q < 4; q++) begin
            i_agc_host.wr(8'h02, {3'h0, q[1:0], 3'h1});
            n = 0;
            for (int i = 0; i < 200; i++) begin
                @(posedge core_clk);
                n += reference_quick_charge;
            end
            check("qchg", n >= QL[q] && n <= QH[q], 1);
            check("awake", sleep_mode, 0);
            i_agc_host.wr(8'h02, 8'h00);
            wt(3);
            check("asleep", sleep_mode, 1);
        end
        check("pins", i2c_target_address, 7'h49);
        $display("sleep done");
    endtask

    task automatic shdn(input logic [7:0] cfg, output int n);
        i_agc_host.wr(8'h05, cfg);
        @(posedge core_clk);
        shutdown_pin_n <= 1'b0;
        n = 0;
        while (digital_regulator_enable !== 1'b0 && n < 300) begin
            @(posedge core_clk);
            n++;
        end
    endtask

    task automatic rel();
        @(posedge core_clk);
        shutdown_pin_n <= 1'b1;
        clean_shutdown_done <= 1'b0;
        wt(3);
        check("reg back", digital_regulator_enable, 1);
    endtask

    task automatic t_shutdown();
        int n;
        shdn(8'h00, n);
        check("immediate", n <= 4, 1);
        rel();
        shdn(8'h0c, n);
        check("code 3", n <= 4, 1);
        rel();
        for (int k = 0; k < 4; k++) begin
            shdn({6'h01, k[1:0]}, n);
            check("keepalive", n >= KL[k] && n <= KH[k], 1);
            rel();
        end
        shdn(8'h08, n);
        check("clean hold", n, 300);
        @(posedge core_clk);
        clean_shutdown_done <= 1'b1;
        wt(3);
        check("clean off", digital_regulator_enable, 0);
        rel();
        $display("shutdown done");
    endtask

    task automatic t_soft_reset();
        logic seen;
        seen = 1'b0;
        i_agc_host.wr(8'h07, 8'h4a);
        i_agc_host.wr(8'h02, 8'h0d);
        i_agc_host.wr(8'h05, 8'h0e);
        i_agc_host.wr(8'h01, 8'h01);
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            seen |= soft_reset_pulse;
        end
        check("pulse", seen, 1);
        rdc(8'h01, 8'h00);
        rdc(8'h07, 8'h30);
        rdc(8'h02, 8'h00);
        rdc(8'h05, 8'h05);
        check("sleep", sleep_mode, 1);
        $display("soft reset done");
    endtask

    initial begin
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        t_defaults();
        t_paging_reserved();
        t_audio();
        t_sleep();
        t_shutdown();
        t_soft_reset();
        stop_test();
    end
endmodule
`default_nettype wire
